//--- design/card_seq_pkg.sv
// Constants and carrier types for the smart card session sequencer.
// Assumes a single 250 MHz system clock that also serves as card clock source.
package card_seq_pkg;

  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;

  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WARM = 1;
  localparam int CTRL_VSEL = 2;
  localparam int CTRL_CSTOP = 3;
  localparam int CTRL_CSTOP_LVL = 4;
  localparam int CTRL_DIV_LO = 5;
  localparam int CTRL_DIV_HI = 6;
  localparam int CTRL_IO_EN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_PRES = 0;
  localparam int STAT_PRES_CHG = 1;
  localparam int STAT_IO = 2;
  localparam int STAT_SUPPLY = 3;
  localparam int STAT_PROTECTION_FLAG = 4;
  localparam int STAT_MUTE = 5;
  localparam int STAT_EARLY = 6;
  localparam int STAT_ACTIVE = 7;
  localparam logic [7:0] STAT_RESET = 8'h04;

  // Timing: one sequencer step t1..t4 and the supply settle window
  localparam int CLK_MHZ = 250;
  localparam int T_STEP_NS = 1000;
  localparam int T_STEP_CYC = (T_STEP_NS * CLK_MHZ + 999) / 1000;

  // Card clock cycle counts
  localparam int EARLY_CARD_CYC = 400;
  localparam int MUTE_CARD_CYC = 40000;
  localparam int WARM_CARD_CYC = 42000;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h0,
    SEQ_ACT1 = 4'h1,
    SEQ_ACT2 = 4'h3,
    SEQ_ACT3 = 4'h2,
    SEQ_RUN = 4'h6,
    SEQ_DEA1 = 4'h7,
    SEQ_DEA2 = 4'h5,
    SEQ_DEA3 = 4'h4,
    SEQ_DEA4 = 4'hC
  } seq_state_type;

  typedef enum logic [1:0] {
    IO_NEUTRAL = 2'h0,
    IO_HOST_IN = 2'h1,
    IO_CARD_IN = 2'h3
  } io_mode_type;

  // Asynchronous pin inputs, all active high
  typedef struct packed {
    logic logic_ok;
    logic regulator_ok;
    logic card_ok;
    logic regulator_below_card;
    logic over_current;
    logic over_temp;
    logic card_present;
    logic card_io;
    logic host_io;
  } pin_in_type;

endpackage : card_seq_pkg

//--- design/card_session_seq.sv
// Smart card session sequencer: activation, deactivation, card clock,
// warm reset, status flags, host interrupt and I/O direction arbitration.
// Assumes pin inputs are asynchronous and both I/O lines have pull-ups.
//
// Functional notes
// - Any supply supervisor fault forces deactivation
// - Regulator below card supply is a fault
// - Logic supply starts sequencer, fault deactivates card
// - Control bit 2 selects card voltage
// - Over-temperature deactivates, sets bit 4, interrupts
// - Card clock divides by 8, 4, 2, 1
// - Interrupt low until logic supply stable
// - Activation: supply, reception, clock, reset in order
// - Card supply invalid after t1 aborts session
// - Host stop or hardware fault starts deactivation
// - Deactivation: reset, clock, I/O low, supply off
// - Interrupt low on any supply fault
// - Interrupt on early, mute, presence, protection
// - Status read releases status-caused interrupt
// - Reset returns both registers to defaults; status is never loaded with STAT_RESET, only its sticky flags clear
// - Logic fault holds interrupt until stable t1
// - Control bit 1 gives 42000-cycle warm reset
// - Warm bit self-clears on answer or mute
// - Card I/O and aux low until reception
// - Host I/O and aux lines high after reset
// - First falling line becomes input, copied across
// - Rising edge on input returns lines neutral
// - Mute flag after 40000 silent card cycles
// - Early flag for answer under 400 cycles
// - Mute and early flags cleared at session start
`timescale 1ns/10ps
`default_nettype none

module card_session_seq #(
  parameter int EARLY_CYC = card_seq_pkg::EARLY_CARD_CYC,
  parameter int MUTE_CYC = card_seq_pkg::MUTE_CARD_CYC,
  parameter int WARM_CYC = card_seq_pkg::WARM_CARD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Asynchronous pins
  input wire card_seq_pkg::pin_in_type pins,
  // Card side
  output logic card_supply_en,
  output logic card_voltage_select,
  output logic card_rst,
  output logic card_clk,
  output logic card_io_out,
  output logic card_io_oe,
  output logic [1:0] card_aux_out,
  // Host side
  output logic host_io_out,
  output logic host_io_oe,
  output logic [1:0] host_aux_out,
  output logic int_n
);

  localparam int TW = $clog2(card_seq_pkg::T_STEP_CYC + 1);

  card_seq_pkg::pin_in_type sync_a, sync_b;
  card_seq_pkg::seq_state_type state, next_state;
  card_seq_pkg::io_mode_type io_mode;
  logic [7:0] ctrl;
  logic [TW-1:0] step_cnt, vdd_cnt;
  logic vdd_stable, pres_prev, card_prev, host_prev;
  logic pres_chg, sup_flag, protection_flag_flag, mute, early, mute_irq, early_irq;
  logic [2:0] div_cnt;
  logic card_clk_q, card_tick, clk_phase, reception, rx_now;
  logic atr_wait, warm_hold;
  logic [15:0] atr_cnt;
  logic step_done, in_session, card_fault, supply_fault, hw_fault, abort;
  logic card_fall, card_rise, host_fall, host_rise, answer, warm_clear;
  logic rd_stat, sess_start;
  logic [1:0] div_sel;
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pres_prev <= 1'b0;
      card_prev <= 1'b0;
      host_prev <= 1'b1;
    end else begin
      pres_prev <= sync_b.card_present;
      card_prev <= sync_b.card_io;
      host_prev <= sync_b.host_io;
    end
  end

  assign card_fall = card_prev && !sync_b.card_io;
  assign card_rise = !card_prev && sync_b.card_io;
  assign host_fall = host_prev && !sync_b.host_io;
  assign host_rise = !host_prev && sync_b.host_io;

  ////////////////////////////////////////////////////////////////////////
  // Fault decode

  assign in_session = (state == card_seq_pkg::SEQ_ACT1) || (state == card_seq_pkg::SEQ_ACT2)
    || (state == card_seq_pkg::SEQ_ACT3) || (state == card_seq_pkg::SEQ_RUN);
  // Card supply judged from the end of t1 on, so an abort also stops the run
  assign card_fault = !sync_b.card_ok && in_session
    && ((state != card_seq_pkg::SEQ_ACT1) || step_done);
  assign supply_fault = !sync_b.logic_ok || !sync_b.regulator_ok
    || sync_b.regulator_below_card || card_fault;
  assign hw_fault = supply_fault || sync_b.over_current || sync_b.over_temp
    || !sync_b.card_present;
  assign abort = !ctrl[card_seq_pkg::CTRL_RUN] || hw_fault;
  assign step_done = step_cnt == TW'(card_seq_pkg::T_STEP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Activation / deactivation sequencer

  always_comb begin
    next_state = state;
    case (state)
      card_seq_pkg::SEQ_IDLE: begin
        if (ctrl[card_seq_pkg::CTRL_RUN] && !hw_fault && vdd_stable) begin
          next_state = card_seq_pkg::SEQ_ACT1;
        end
      end
      card_seq_pkg::SEQ_ACT1: begin
        if (abort) begin
          next_state = card_seq_pkg::SEQ_DEA1;
        end else if (step_done) begin
          next_state = sync_b.card_ok ? card_seq_pkg::SEQ_ACT2
            : card_seq_pkg::SEQ_DEA1;
        end
      end
      card_seq_pkg::SEQ_ACT2: begin
        if (abort) next_state = card_seq_pkg::SEQ_DEA1;
        else if (step_done) next_state = card_seq_pkg::SEQ_ACT3;
      end
      card_seq_pkg::SEQ_ACT3: begin
        if (abort) next_state = card_seq_pkg::SEQ_DEA1;
        else if (step_done) next_state = card_seq_pkg::SEQ_RUN;
      end
      card_seq_pkg::SEQ_RUN: begin
        if (abort) next_state = card_seq_pkg::SEQ_DEA1;
      end
      card_seq_pkg::SEQ_DEA1: if (step_done) next_state = card_seq_pkg::SEQ_DEA2;
      card_seq_pkg::SEQ_DEA2: if (step_done) next_state = card_seq_pkg::SEQ_DEA3;
      card_seq_pkg::SEQ_DEA3: if (step_done) next_state = card_seq_pkg::SEQ_DEA4;
      card_seq_pkg::SEQ_DEA4: if (step_done) next_state = card_seq_pkg::SEQ_IDLE;
      default: next_state = card_seq_pkg::SEQ_IDLE;
    endcase
  end

  assign sess_start = (state == card_seq_pkg::SEQ_IDLE) && (next_state == card_seq_pkg::SEQ_ACT1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= card_seq_pkg::SEQ_IDLE;
      step_cnt <= '0;
    end else begin
      state <= next_state;
      step_cnt <= (next_state != state) ? '0 : step_cnt + TW'(1);
    end
  end

  // One reception term, so card I/O and aux switch with the other card pins
  assign rx_now = (in_session && (state != card_seq_pkg::SEQ_ACT1))
    || (state == card_seq_pkg::SEQ_DEA1) || (state == card_seq_pkg::SEQ_DEA2)
    || (state == card_seq_pkg::SEQ_DEA3);

  // Card pin levels follow the sequencer step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      card_supply_en <= 1'b0;
      reception <= 1'b0;
      clk_phase <= 1'b0;
      card_rst <= 1'b0;
    end else begin
      card_supply_en <= state != card_seq_pkg::SEQ_IDLE;
      reception <= rx_now;
      clk_phase <= (state == card_seq_pkg::SEQ_ACT3) || (state == card_seq_pkg::SEQ_RUN)
        || (state == card_seq_pkg::SEQ_DEA1) || (state == card_seq_pkg::SEQ_DEA2);
      card_rst <= ((state == card_seq_pkg::SEQ_RUN) || (state == card_seq_pkg::SEQ_DEA1))
        && !warm_hold;
    end
  end

  assign card_voltage_select = ctrl[card_seq_pkg::CTRL_VSEL];

  ////////////////////////////////////////////////////////////////////////
  // Card clock divider

  assign div_sel = {ctrl[card_seq_pkg::CTRL_DIV_HI], ctrl[card_seq_pkg::CTRL_DIV_LO]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt <= 3'h0;
      card_clk_q <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
      if (!clk_phase || ctrl[card_seq_pkg::CTRL_CSTOP]) begin
        card_clk_q <= clk_phase && ctrl[card_seq_pkg::CTRL_CSTOP_LVL];
      end else begin
        case (div_sel)
          2'h0: card_clk_q <= div_cnt[2];
          2'h1: card_clk_q <= div_cnt[1];
          default: card_clk_q <= div_cnt[0];
        endcase
      end
    end
  end

  // Undivided rate passes the source clock straight through
  assign card_clk = (div_sel == 2'h3 && clk_phase && !ctrl[card_seq_pkg::CTRL_CSTOP])
    ? clk : card_clk_q;

  always_comb begin
    case (div_sel)
      2'h0: card_tick = div_cnt == 3'h7;
      2'h1: card_tick = div_cnt[1:0] == 2'h3;
      2'h2: card_tick = div_cnt[0];
      default: card_tick = 1'b1;
    endcase
    card_tick = card_tick && clk_phase && !ctrl[card_seq_pkg::CTRL_CSTOP];
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer-to-reset window and warm reset

  assign answer = atr_wait && card_fall && (io_mode != card_seq_pkg::IO_HOST_IN);
  assign warm_clear = answer || (atr_wait && card_tick && atr_cnt == 16'(MUTE_CYC - 1));

  always_ff @(posedge clk) begin
    if (sys_rst || state != card_seq_pkg::SEQ_RUN) begin
      atr_wait <= 1'b0;
      warm_hold <= 1'b0;
      atr_cnt <= 16'h0000;
    end else if (!atr_wait && !warm_hold && card_rst
      && (atr_cnt == 16'h0000 || ctrl[card_seq_pkg::CTRL_WARM])) begin
      // Count of one marks a closed window; only a warm request reopens it
      atr_wait <= !ctrl[card_seq_pkg::CTRL_WARM] && (atr_cnt == 16'h0000);
      warm_hold <= ctrl[card_seq_pkg::CTRL_WARM];
      atr_cnt <= 16'h0000;
    end else if (warm_hold) begin
      if (card_tick) begin
        atr_cnt <= (atr_cnt == 16'(WARM_CYC - 1)) ? 16'h0000 : atr_cnt + 16'h0001;
        if (atr_cnt == 16'(WARM_CYC - 1)) begin
          warm_hold <= 1'b0;
          atr_wait <= 1'b1;
        end
      end
    end else if (atr_wait) begin
      if (warm_clear) begin
        atr_wait <= 1'b0;
        atr_cnt <= 16'h0001;
      end else if (card_tick) begin
        atr_cnt <= atr_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || sess_start) begin
      mute <= 1'b0;
      early <= 1'b0;
    end else begin
      if (atr_wait && !answer && card_tick && atr_cnt == 16'(MUTE_CYC - 1)) begin
        mute <= 1'b1;
      end
      if (answer && atr_cnt < 16'(EARLY_CYC)) begin
        early <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, flags and read port

  assign rd_stat = reg_rd && reg_addr == card_seq_pkg::ADDR_STAT;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= card_seq_pkg::CTRL_RESET;
    end else begin
      if (reg_wr && reg_addr == card_seq_pkg::ADDR_CTRL) begin
        ctrl <= reg_wdata;
      end
      // Hardware clears win over a same-cycle host write
      if (in_session && hw_fault) begin
        ctrl[card_seq_pkg::CTRL_RUN] <= 1'b0;
      end
      if (warm_clear) begin
        ctrl[card_seq_pkg::CTRL_WARM] <= 1'b0;
      end
    end
  end

  // Sticky flags: read clears, same-cycle event wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pres_chg <= 1'b0;
      sup_flag <= 1'b0;
      protection_flag_flag <= 1'b0;
      mute_irq <= 1'b0;
      early_irq <= 1'b0;
    end else begin
      pres_chg <= (pres_chg && !rd_stat) || (pres_prev != sync_b.card_present);
      sup_flag <= (sup_flag && !rd_stat) || supply_fault;
      protection_flag_flag <= (protection_flag_flag && !rd_stat)
        || (in_session && (sync_b.over_current || sync_b.over_temp));
      mute_irq <= (mute_irq && !rd_stat) || (!mute && atr_wait && !answer && card_tick
        && atr_cnt == 16'(MUTE_CYC - 1));
      early_irq <= (early_irq && !rd_stat) || (answer && atr_cnt < 16'(EARLY_CYC));
    end
  end

  assign status = {
    state != card_seq_pkg::SEQ_IDLE, early, mute, protection_flag_flag,
    sup_flag, sync_b.card_io, pres_chg, sync_b.card_present
  };

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (rd_stat) begin
      reg_rdata <= status;
    end else if (reg_rd && reg_addr == card_seq_pkg::ADDR_CTRL) begin
      reg_rdata <= ctrl;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Logic supply settle timer and interrupt

  always_ff @(posedge clk) begin
    if (sys_rst || !sync_b.logic_ok) begin
      vdd_cnt <= '0;
      vdd_stable <= 1'b0;
    end else if (!vdd_stable) begin
      vdd_cnt <= vdd_cnt + TW'(1);
      vdd_stable <= vdd_cnt == TW'(card_seq_pkg::T_STEP_CYC - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_n <= 1'b0;
    end else begin
      int_n <= !(supply_fault || !vdd_stable || pres_chg || sup_flag || protection_flag_flag
        || mute_irq || early_irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // I/O direction arbitration

  always_ff @(posedge clk) begin
    if (sys_rst || !reception || !ctrl[card_seq_pkg::CTRL_IO_EN]) begin
      io_mode <= card_seq_pkg::IO_NEUTRAL;
    end else begin
      case (io_mode)
        card_seq_pkg::IO_NEUTRAL: begin
          if (host_fall) io_mode <= card_seq_pkg::IO_HOST_IN;
          else if (card_fall) io_mode <= card_seq_pkg::IO_CARD_IN;
        end
        card_seq_pkg::IO_HOST_IN: if (host_rise) io_mode <= card_seq_pkg::IO_NEUTRAL;
        card_seq_pkg::IO_CARD_IN: if (card_rise) io_mode <= card_seq_pkg::IO_NEUTRAL;
        default: io_mode <= card_seq_pkg::IO_NEUTRAL;
      endcase
    end
  end

  // Open-drain style: drive low only, released lines idle high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      card_io_oe <= 1'b1;
      host_io_oe <= 1'b0;
      card_aux_out <= 2'h0;
      host_aux_out <= 2'h3;
    end else begin
      card_io_oe <= !rx_now
        || (io_mode == card_seq_pkg::IO_HOST_IN && !sync_b.host_io);
      host_io_oe <= io_mode == card_seq_pkg::IO_CARD_IN && !sync_b.card_io;
      card_aux_out <= {2{rx_now}};
      host_aux_out <= 2'h3;
    end
  end

  assign card_io_out = 1'b0;
  assign host_io_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_fault_deact;
    (state == card_seq_pkg::SEQ_RUN) && hw_fault |=> state == card_seq_pkg::SEQ_DEA1;
  endproperty
  a_fault_deact: assert property (p_fault_deact)
    else $error("fault in session did not start deactivation");

  property p_vcc_abort;
    (state == card_seq_pkg::SEQ_ACT1) && step_done && !sync_b.card_ok
      |=> state == card_seq_pkg::SEQ_DEA1;
  endproperty
  a_vcc_abort: assert property (p_vcc_abort)
    else $error("invalid card supply did not abort activation");

  property p_supply_int;
    !sync_b.regulator_ok |=> !int_n;
  endproperty
  a_supply_int: assert property (p_supply_int)
    else $error("supply fault did not assert interrupt");

  property p_vdd_hold;
    $fell(sync_b.logic_ok) |=> !int_n [*2];
  endproperty
  a_vdd_hold: assert property (p_vdd_hold)
    else $error("interrupt released too soon after logic fault");

  property p_rd_clear;
    rd_stat && !supply_fault && !hw_fault && !in_session && (pres_prev == sync_b.card_present)
      |=> !pres_chg && !sup_flag && !protection_flag_flag;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("status read did not clear sticky flags");

  property p_temp_protection_flag;
    in_session && sync_b.over_temp |=> protection_flag_flag ##1 !int_n;
  endproperty
  a_temp_protection_flag: assert property (p_temp_protection_flag)
    else $error("over-temperature not reported");

  property p_rst_order;
    (state == card_seq_pkg::SEQ_DEA2) |=> !card_rst && card_supply_en;
  endproperty
  a_rst_order: assert property (p_rst_order)
    else $error("card reset or supply wrong in deactivation");

  property p_act_order;
    $rose(card_rst) |-> reception && card_supply_en && clk_phase;
  endproperty
  a_act_order: assert property (p_act_order)
    else $error("card reset raised before supply, reception or clock");

  property p_early;
    answer && atr_cnt < 16'(EARLY_CYC) |=> early && warm_clear == 1'b0;
  endproperty
  a_early: assert property (p_early)
    else $error("early answer not flagged");

  property p_div8;
    (div_sel == 2'h0) && card_tick |=> (!card_tick || (div_sel != 2'h0)) [*7];
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by eight tick spacing wrong");

endmodule : card_session_seq

`default_nettype wire

//--- test/card_model.sv
// Behavioural smart card that answers each reset with a low pulse on its I/O line.
// Assumes card_clk only toggles while the sequencer runs the card clock.
`timescale 1ns/10ps
`default_nettype none

module card_model (
  // Clock
  input wire logic clk,
  // Contacts
  input wire logic card_supply_en,
  input wire logic card_rst,
  input wire logic card_clk,
  // Behaviour: card clock ticks to the answer, zero stays mute
  input wire logic [15:0] answer_ticks,
  output logic card_pull
);
  logic [15:0] ticks;

  // Ticks since reset went high
  always_ff @(posedge card_clk or negedge card_rst) begin
    if (!card_rst) begin
      ticks <= 16'h0000;
    end else if (ticks != 16'hFFFF) begin
      ticks <= ticks + 16'h0001;
    end
  end

  // Eight ticks low, only while powered and out of reset
  always_ff @(posedge clk) begin
    card_pull <= card_supply_en && card_rst && (answer_ticks != 16'h0000) &&
      (ticks >= answer_ticks) && (ticks < answer_ticks + 16'h0008);
  end
endmodule : card_model

`default_nettype wire

//--- test/smart_card_session_sequencer_tb.sv
// Bench for the session sequencer: register port, activation, divider,
// answer flags, warm reset, deactivation timing, faults and I/O copy.
// Assumes the design package, the design and the card model are compiled.
`timescale 1ns/10ps
`default_nettype none

module smart_card_session_sequencer_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] sup = 7'h71;
  logic [15:0] answer = 16'h0014;
  logic [7:0] reg_rdata, d;
  logic [1:0] card_aux_out, host_aux_out;
  logic card_supply_en, card_voltage_select, card_rst, card_clk, card_io_out, card_io_oe;
  logic host_io_out, host_io_oe, int_n, card_pull, card_line;
  logic host_pull = 1'b0;
  logic [3:0] obs;
  card_seq_pkg::pin_in_type pins;
  int errors = 0;
  int checks = 0;
  int n;
  int p;
  logic [6:0] mask [7] = '{7'h08, 7'h04, 7'h02, 7'h01, 7'h10, 7'h20, 7'h40};
  int flag [7] = '{3, 4, 4, 1, 3, 3, 3};

  // Pull-ups on both I/O lines
  assign card_line = !(card_io_oe || card_pull === 1'b1);
  assign pins = {sup, card_line, !(host_io_oe || host_pull)};
  assign obs = {int_n, card_rst, card_io_oe, card_supply_en};
  always #2 clk = ~clk;

  card_session_seq #(.EARLY_CYC(8), .MUTE_CYC(40), .WARM_CYC(42)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
    .card_supply_en(card_supply_en), .card_voltage_select(card_voltage_select),
    .card_rst(card_rst), .card_clk(card_clk), .card_io_out(card_io_out),
    .card_io_oe(card_io_oe), .card_aux_out(card_aux_out), .host_io_out(host_io_out),
    .host_io_oe(host_io_oe), .host_aux_out(host_aux_out), .int_n(int_n));

  card_model i_card (.clk(clk), .card_supply_en(card_supply_en), .card_rst(card_rst),
    .card_clk(card_clk), .answer_ticks(answer), .card_pull(card_pull));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cycles

  // Cycles until an observed output reaches a level
  task automatic wait_for(input int sel, input logic val);
    n = 0;
    do begin
      cycles(1);
      n++;
    end while (obs[sel] !== val && n < 3000);
    if (n >= 3000) chk("wait", 16'h0000, 16'h0001);
  endtask : wait_for

  task automatic period;
    logic prev;
    int k;
    p = 0;
    k = 0;
    prev = card_clk;
    while (k < 2 && p < 100) begin
      cycles(1);
      if (k == 1) p++;
      if (card_clk && !prev) k++;
      prev = card_clk;
    end
  endtask : period

  task automatic start(input logic [7:0] c);
    wr(card_seq_pkg::ADDR_CTRL, c);
    wait_for(0, 1'b1);
    wait_for(1, 1'b0);
    chk("supply to reception", 16'(card_seq_pkg::T_STEP_CYC), 16'(n));
    chk("card aux", 16'h0003, 16'(card_aux_out));
    wait_for(2, 1'b1);
    chk("reception to reset", 16'(2 * card_seq_pkg::T_STEP_CYC), 16'(n));
  endtask : start

  task automatic stop;
    wr(card_seq_pkg::ADDR_CTRL, 8'h80);
    wait_for(2, 1'b0);
    wait_for(1, 1'b1);
    chk("reset to io low", 16'(2 * card_seq_pkg::T_STEP_CYC), 16'(n));
    chk("clock low", 16'h0000, 16'(card_clk));
    wait_for(0, 1'b0);
    chk("io low to supply off", 16'(card_seq_pkg::T_STEP_CYC), 16'(n));
  endtask : stop

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (19) @(posedge clk);
    #1;
    chk("reset pins", 16'h0046, 16'({card_io_out, host_io_out, card_supply_en, card_rst,
      card_io_oe, host_io_oe, card_aux_out, host_aux_out, int_n}));
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(card_seq_pkg::ADDR_CTRL);
    chk("control reset", 16'h0000, 16'(d));
    wr(2'h2, 8'hFF);
    rd(2'h2);
    chk("unmapped read", 16'h0000, 16'(d));
    rd(card_seq_pkg::ADDR_CTRL);
    chk("control kept", 16'h0000, 16'(d));
    cycles(300);
    rd(card_seq_pkg::ADDR_STAT);
    chk("present idle", 16'h0001, 16'(d & 8'h81));
    cycles(3);
    chk("int released", 16'h0001, 16'(int_n));
    $display("test registers done");
    start(8'hC1);
    n = 0;
    while (card_pull !== 1'b1 && n < 200) begin
      cycles(1);
      n++;
    end
    cycles(6);
    chk("host line copy", 16'h0001, 16'(host_io_oe));
    cycles(24);
    chk("host line neutral", 16'h0000, 16'(host_io_oe));
    @(posedge clk);
    host_pull <= 1'b1;
    cycles(6);
    chk("card line copy", 16'h0001, 16'(card_io_oe));
    @(posedge clk);
    host_pull <= 1'b0;
    cycles(6);
    chk("card line neutral", 16'h0000, 16'(card_io_oe));
    rd(card_seq_pkg::ADDR_STAT);
    chk("answer flags", 16'h0080, 16'(d & 8'hE0));
    for (int i = 0; i < 3; i++) begin
      wr(card_seq_pkg::ADDR_CTRL, 8'h81 | 8'(i << 5) | (8'(i << 2) & 8'h04));
      period();
      period();
      chk("card clock period", 16'(8 >> i), 16'(p));
      chk("voltage select", 16'(i & 1), 16'(card_voltage_select));
    end
    stop();
    $display("test session done");
    answer <= 16'h0000;
    start(8'hC1);
    cycles(150);
    rd(card_seq_pkg::ADDR_STAT);
    chk("mute flag", 16'h0020, 16'(d & 8'h60));
    wr(card_seq_pkg::ADDR_CTRL, 8'hC3);
    wait_for(2, 1'b0);
    wait_for(2, 1'b1);
    chk("warm length", 16'h0001, 16'(n > 80 && n < 88));
    cycles(150);
    rd(card_seq_pkg::ADDR_CTRL);
    chk("warm bit", 16'h0000, 16'(d[1]));
    stop();
    $display("test mute and warm done");
    answer <= 16'h0004;
    start(8'hC1);
    cycles(60);
    chk("early int", 16'h0000, 16'(int_n));
    rd(card_seq_pkg::ADDR_STAT);
    chk("early flag", 16'h0040, 16'(d & 8'h60));
    cycles(3);
    chk("int after read", 16'h0001, 16'(int_n));
    stop();
    $display("test early done");
    answer <= 16'h0014;
    wr(card_seq_pkg::ADDR_CTRL, 8'hC1);
    wait_for(0, 1'b1);
    @(posedge clk);
    sup <= 7'h61;
    wait_for(0, 1'b0);
    rd(card_seq_pkg::ADDR_CTRL);
    chk("run after abort", 16'h0000, 16'(d[0]));
    rd(card_seq_pkg::ADDR_STAT);
    chk("abort flag", 16'h0001, 16'(d[3]));
    @(posedge clk);
    sup <= 7'h71;
    cycles(300);
    rd(card_seq_pkg::ADDR_STAT);
    $display("test abort done");
    for (int f = 0; f < 7; f++) begin
      start(8'hC1);
      @(posedge clk);
      sup <= 7'h71 ^ mask[f];
      wait_for(0, 1'b0);
      chk("fault int", 16'h0000, 16'(int_n));
      rd(card_seq_pkg::ADDR_STAT);
      chk("fault flag", 16'h0001, 16'(d[flag[f]]));
      @(posedge clk);
      sup <= 7'h71;
      cycles(20);
      rd(card_seq_pkg::ADDR_STAT);
      cycles(5);
      chk("int after fault", 16'(f != 6), 16'(int_n));
      cycles(300);
    end
    $display("test faults done");
    print_verdict();
  end
endmodule : smart_card_session_sequencer_tb

`default_nettype wire
